// ==== pcg_osc_model.sv ====
// crystal oscillator model at the primary oscillator pin
// free running; held low while disabled
`timescale 1ns/1ps
module pcg_osc_model #(
    parameter int HALF_NS = 50
) (
    input wire logic en_i,
    output logic osc_o
);
    initial osc_o = 1'b0;
    always begin
        #(HALF_NS);
        osc_o = en_i ? ~osc_o : 1'b0;
    end
endmodule

// ==== pcg_pkg.sv ====
// constants, field layouts and carriers for the clock generation block
// assumes a single core clock; oscillator pins arrive asynchronously
package pcg_pkg;

    // ****************************************
    // clock_divider field layout
    // ****************************************
    localparam int PRE_LSB = 0;
    localparam int PRE_W = 5;
    localparam int POST_LSB = 6;
    localparam int POST_W = 2;
    localparam int CDIV_W = 8;
    localparam logic [CDIV_W-1:0] CDIV_RST = 8'h00;

    // ****************************************
    // pll_feedback_divisor field layout
    // ****************************************
    localparam int FBD_W = 9;
    localparam logic [FBD_W-1:0] FBD_RST = 9'h030;

    // ****************************************
    // factor encodings
    // ****************************************
    localparam int MULT_W = 10;
    localparam int PREF_W = 6;
    localparam int POSTF_W = 4;
    localparam int DIV_W = 9;
    localparam int IDIV_W = 10;
    localparam logic [MULT_W-1:0] FBD_OFFSET = 10'h002;
    localparam logic [PREF_W-1:0] PRE_OFFSET = 6'h02;
    localparam logic [POST_W-1:0] POST_CODE_DIV2 = 2'h0;
    localparam logic [POST_W-1:0] POST_CODE_DIV4 = 2'h1;
    localparam logic [POSTF_W-1:0] POST_DIV2 = 4'h2;
    localparam logic [POSTF_W-1:0] POST_DIV4 = 4'h4;
    localparam logic [POSTF_W-1:0] POST_DIV8 = 4'h8;
    localparam logic [MULT_W-1:0] MULT_BYPASS = 10'h001;
    localparam logic [DIV_W-1:0] DIV_BYPASS = 9'h001;
    localparam int AUX_MULT_W = 5;
    localparam logic [AUX_MULT_W-1:0] AUX_MULT = 5'h10;
    localparam logic [AUX_MULT_W-1:0] AUX_BYPASS = 5'h01;

    // ****************************************
    // timing and sizing defaults
    // ****************************************
    localparam int LOCK_CYCLES_DEF = 16;
    localparam int REF_RATIO_W_DEF = 8;
    localparam int SYNC_STAGES = 3;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [POST_W-1:0] pll_postscale;
        logic [PRE_W-1:0] pll_prescale;
    } pcg_cdiv_s;

    typedef struct packed {
        logic [MULT_W-1:0] mult;
        logic [DIV_W-1:0] div;
        logic [IDIV_W-1:0] idiv;
    } pcg_ratio_s;

endpackage

// ==== pcg_ref_div.sv ====
// reference clock scaler: divides a same-domain clock level by a ratio
// assumes src_lvl_i is already free of metastability
`timescale 1ns/1ps
module pcg_ref_div #(
    parameter int RATIO_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic src_lvl_i,
    input wire logic [RATIO_W-1:0] ratio_i,
    output logic clk_o
);

    // ****************************************
    // half-period edge counter
    // ****************************************
    logic [RATIO_W-1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic prev_q, prev_d;
    logic [RATIO_W-1:0] ratio_eff;

    always_comb begin
        ratio_eff = (ratio_i == '0) ? {{(RATIO_W-1){1'b0}}, 1'b1} : ratio_i;
        prev_d = src_lvl_i;
        cnt_d = cnt_q;
        out_d = out_q;
        if (!en_i) begin
            cnt_d = '0;
            out_d = 1'b0;
        end else if (src_lvl_i != prev_q) begin
            // toggle after ratio source edges: period is ratio source periods
            if (cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1} >= ratio_eff) begin
                cnt_d = '0;
                out_d = ~out_q;
            end else begin
                cnt_d = cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            out_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            prev_q <= prev_d;
        end
    end

    assign clk_o = out_q;

endmodule

// ==== pcg_top.sv ====
// clock generation control: divisor registers, factor computation,
// auxiliary path selection, lock tracking and reference clock output
// assumes a power-on reset pulse on POR_I and a crystal level on a pin
`timescale 1ns/1ps

// What this block does
// - pll optional, primary or fast rc source
// - prescale divides input by 2 to 33
// - prescale from clock_divider bits 4:0, zero=2
// - multiplier from pll_feedback_divisor bits 8:0
// - multiplier equals feedback field plus two
// - postscale 2/4/8 from clock_divider bits 7:6
// - postscale code 00 divides by two
// - fosc equals input times m over n1n2
// - instruction rate is fosc over two
// - auxiliary pll from primary or fast rc
// - auxiliary pll multiplies by fixed sixteen
// - finest pwm resolution only via auxiliary pll
// - reference clock from system or crystal, scaled
// - feedback register reset to 0x030 only by power-on
module pcg_top
    import pcg_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYCLES_DEF,
    parameter int REF_RATIO_W = REF_RATIO_W_DEF
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic CLOCK_DIVIDER_WE_I,
    input wire logic [CDIV_W-1:0] CLOCK_DIVIDER_WDATA_I,
    output logic [CDIV_W-1:0] CLOCK_DIVIDER_RDATA_O,
    input wire logic PLL_FEEDBACK_DIVISOR_WE_I,
    input wire logic [FBD_W-1:0] PLL_FEEDBACK_DIVISOR_WDATA_I,
    output logic [FBD_W-1:0] PLL_FEEDBACK_DIVISOR_RDATA_O,
    input wire logic PLL_SRC_RC_I,
    input wire logic PLL_ENABLE_I,
    input wire logic AUX_SRC_RC_I,
    input wire logic AUX_PLL_ENABLE_I,
    input wire logic REF_ENABLE_I,
    input wire logic REF_SRC_XTAL_I,
    input wire logic [REF_RATIO_W-1:0] REF_RATIO_I,
    input wire logic PRIMARY_OSC_I,
    input wire logic SYS_CLK_LEVEL_I,
    output logic SYS_SRC_RC_O,
    output logic SYS_PLL_ACTIVE_O,
    output logic [MULT_W-1:0] SYS_MULT_O,
    output logic [DIV_W-1:0] SYS_DIV_O,
    output logic [IDIV_W-1:0] INSTR_DIV_O,
    output logic PLL_LOCK_O,
    output logic AUX_SRC_RC_O,
    output logic [AUX_MULT_W-1:0] AUX_MULT_O,
    output logic AUX_FINE_RES_O,
    output logic REF_CLK_O
);

    localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
    localparam logic [LOCK_W-1:0] LOCK_END = LOCK_W'(LOCK_CYCLES);

    generate
        if (LOCK_CYCLES < 1 || REF_RATIO_W < 1 || REF_RATIO_W > 16) begin : g_bad_param
            $error("pcg_top: unsupported parameter value");
        end
    endgenerate

    logic rst_any;
    assign rst_any = RST_I | POR_I;

    // ****************************************
    // divisor registers
    // ****************************************
    pcg_cdiv_s cdiv_q, cdiv_d;
    logic [FBD_W-1:0] fbd_q, fbd_d;

    always_comb begin
        cdiv_d = cdiv_q;
        if (CLOCK_DIVIDER_WE_I) begin
            cdiv_d.pll_prescale = CLOCK_DIVIDER_WDATA_I[PRE_LSB +: PRE_W];
            cdiv_d.pll_postscale = CLOCK_DIVIDER_WDATA_I[POST_LSB +: POST_W];
        end
    end

    always_comb begin
        fbd_d = fbd_q;
        if (PLL_FEEDBACK_DIVISOR_WE_I) begin
            fbd_d = PLL_FEEDBACK_DIVISOR_WDATA_I;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge rst_any) begin
        if (rst_any) begin
            cdiv_q <= pcg_cdiv_s'({CDIV_RST[POST_LSB +: POST_W], CDIV_RST[PRE_LSB +: PRE_W]});
        end else begin
            cdiv_q <= cdiv_d;
        end
    end

    // only power-on resets the feedback divisor, to FBD_RST
    always_ff @(posedge CORE_CLK_I or posedge POR_I) begin
        if (POR_I) begin
            fbd_q <= FBD_RST;
        end else begin
            fbd_q <= fbd_d;
        end
    end

    assign CLOCK_DIVIDER_RDATA_O = {cdiv_q.pll_postscale, 1'b0, cdiv_q.pll_prescale};
    assign PLL_FEEDBACK_DIVISOR_RDATA_O = fbd_q;

    // ****************************************
    // factor computation
    // ****************************************
    logic [PREF_W-1:0] n1;
    logic [POSTF_W-1:0] n2;
    logic [MULT_W-1:0] m;
    logic [MULT_W-1:0] n1n2_full;
    pcg_ratio_s ratio_q, ratio_d;
    logic sys_rc_q, sys_rc_d;
    logic pll_on_q, pll_on_d;

    always_comb begin
        n1 = {1'b0, cdiv_q.pll_prescale} + PRE_OFFSET;
        m = {1'b0, fbd_q} + FBD_OFFSET;
        case (cdiv_q.pll_postscale)
            POST_CODE_DIV2: n2 = POST_DIV2;
            POST_CODE_DIV4: n2 = POST_DIV4;
            default: n2 = POST_DIV8;
        endcase
        // widen both factors first: 33 x 8 overflows a 6-bit product
        n1n2_full = MULT_W'(n1) * MULT_W'(n2);
        sys_rc_d = PLL_SRC_RC_I;
        pll_on_d = PLL_ENABLE_I;
        if (PLL_ENABLE_I) begin
            ratio_d.mult = m;
            ratio_d.div = n1n2_full[DIV_W-1:0];
        end else begin
            ratio_d.mult = MULT_BYPASS;
            ratio_d.div = DIV_BYPASS;
        end
        ratio_d.idiv = {ratio_d.div, 1'b0};
    end

    always_ff @(posedge CORE_CLK_I or posedge rst_any) begin
        if (rst_any) begin
            ratio_q <= '{mult: MULT_BYPASS, div: DIV_BYPASS, idiv: IDIV_W'({DIV_BYPASS, 1'b0})};
            sys_rc_q <= 1'b0;
            pll_on_q <= 1'b0;
        end else begin
            ratio_q <= ratio_d;
            sys_rc_q <= sys_rc_d;
            pll_on_q <= pll_on_d;
        end
    end

    assign SYS_MULT_O = ratio_q.mult;
    assign SYS_DIV_O = ratio_q.div;
    assign INSTR_DIV_O = ratio_q.idiv;
    assign SYS_SRC_RC_O = sys_rc_q;
    assign SYS_PLL_ACTIVE_O = pll_on_q;

    // ****************************************
    // lock tracking after a pll change
    // ****************************************
    logic [LOCK_W-1:0] lock_cnt_q, lock_cnt_d;
    logic lock_q, lock_d;
    logic pll_change;

    always_comb begin
        pll_change = (ratio_d != ratio_q) || (sys_rc_d != sys_rc_q) || (pll_on_d != pll_on_q);
        lock_cnt_d = lock_cnt_q;
        lock_d = lock_q;
        if (!PLL_ENABLE_I) begin
            lock_cnt_d = '0;
            lock_d = 1'b0;
        end else if (pll_change) begin
            lock_cnt_d = '0;
            lock_d = 1'b0;
        end else if (!lock_q) begin
            if (lock_cnt_q + LOCK_W'(1) >= LOCK_END) begin
                lock_d = 1'b1;
            end
            lock_cnt_d = lock_cnt_q + LOCK_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge rst_any) begin
        if (rst_any) begin
            lock_cnt_q <= '0;
            lock_q <= 1'b0;
        end else begin
            lock_cnt_q <= lock_cnt_d;
            lock_q <= lock_d;
        end
    end

    assign PLL_LOCK_O = lock_q;

    // ****************************************
    // auxiliary clock path
    // ****************************************
    logic aux_rc_q, aux_rc_d;
    logic [AUX_MULT_W-1:0] aux_mult_q, aux_mult_d;
    logic aux_fine_q, aux_fine_d;

    always_comb begin
        aux_rc_d = AUX_SRC_RC_I;
        aux_mult_d = AUX_PLL_ENABLE_I ? AUX_MULT : AUX_BYPASS;
        aux_fine_d = AUX_PLL_ENABLE_I;
    end

    always_ff @(posedge CORE_CLK_I or posedge rst_any) begin
        if (rst_any) begin
            aux_rc_q <= 1'b0;
            aux_mult_q <= AUX_BYPASS;
            aux_fine_q <= 1'b0;
        end else begin
            aux_rc_q <= aux_rc_d;
            aux_mult_q <= aux_mult_d;
            aux_fine_q <= aux_fine_d;
        end
    end

    assign AUX_SRC_RC_O = aux_rc_q;
    assign AUX_MULT_O = aux_mult_q;
    assign AUX_FINE_RES_O = aux_fine_q;

    // ****************************************
    // crystal pin synchroniser and filter
    // ****************************************
    logic [SYNC_STAGES-1:0] xtal_sync_q, xtal_sync_d;
    logic xtal_lvl_q, xtal_lvl_d;
    logic ref_src;

    always_comb begin
        xtal_sync_d = {xtal_sync_q[SYNC_STAGES-2:0], PRIMARY_OSC_I};
        xtal_lvl_d = xtal_lvl_q;
        // a change counts once the second and third stages agree
        if (xtal_sync_q[1] == xtal_sync_q[2]) begin
            xtal_lvl_d = xtal_sync_q[2];
        end
        ref_src = REF_SRC_XTAL_I ? xtal_lvl_q : SYS_CLK_LEVEL_I;
    end

    always_ff @(posedge CORE_CLK_I or posedge rst_any) begin
        if (rst_any) begin
            xtal_sync_q <= '0;
            xtal_lvl_q <= 1'b0;
        end else begin
            xtal_sync_q <= xtal_sync_d;
            xtal_lvl_q <= xtal_lvl_d;
        end
    end

    // ****************************************
    // reference clock scaler
    // ****************************************
    pcg_ref_div #(
        .RATIO_W(REF_RATIO_W)
    ) u_ref_div (
        .clk_i(CORE_CLK_I),
        .rst_i(rst_any),
        .en_i(REF_ENABLE_I),
        .src_lvl_i(ref_src),
        .ratio_i(REF_RATIO_I),
        .clk_o(REF_CLK_O)
    );

endmodule

// ==== pcg_top_props.sv ====
// checker for the clock generation control block
// bound to pcg_top, sees its ports only
`timescale 1ns/1ps
module pcg_chk
    import pcg_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    input wire logic POR_I,
    input wire logic CLOCK_DIVIDER_WE_I,
    input wire logic [CDIV_W-1:0] CLOCK_DIVIDER_WDATA_I,
    input wire logic [CDIV_W-1:0] CLOCK_DIVIDER_RDATA_O,
    input wire logic PLL_FEEDBACK_DIVISOR_WE_I,
    input wire logic [FBD_W-1:0] PLL_FEEDBACK_DIVISOR_WDATA_I,
    input wire logic [FBD_W-1:0] PLL_FEEDBACK_DIVISOR_RDATA_O,
    input wire logic PLL_ENABLE_I,
    input wire logic AUX_PLL_ENABLE_I,
    input wire logic REF_ENABLE_I,
    input wire logic [MULT_W-1:0] SYS_MULT_O,
    input wire logic [DIV_W-1:0] SYS_DIV_O,
    input wire logic [IDIV_W-1:0] INSTR_DIV_O,
    input wire logic [AUX_MULT_W-1:0] AUX_MULT_O,
    input wire logic AUX_FINE_RES_O,
    input wire logic REF_CLK_O
);
    // ****
    // settle counter after any reset
    // ****
    logic [1:0] up_q;
    logic [1:0] up_d;
    wire any_rst = RST_I | POR_I;
    wire up = (up_q == 2'h3);
    always_comb begin
        up_d = up ? up_q : up_q + 2'h1;
    end
    always_ff @(posedge CORE_CLK_I or posedge any_rst) begin
        if (any_rst) begin
            up_q <= 2'h0;
        end else begin
            up_q <= up_d;
        end
    end
    function automatic logic [DIV_W-1:0] n1n2(input logic [CDIV_W-1:0] c);
        logic [DIV_W-1:0] n2;
        n2 = c[7] ? 9'h008 : (c[6] ? 9'h004 : 9'h002);
        n1n2 = (9'(c[4:0]) + 9'h002) * n2;
    endfunction
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (any_rst);
    AST_FBD_WR: assert property (PLL_FEEDBACK_DIVISOR_WE_I |=>
        PLL_FEEDBACK_DIVISOR_RDATA_O == $past(PLL_FEEDBACK_DIVISOR_WDATA_I)) else $error("feedback write lost");
    AST_CKD_WR: assert property (CLOCK_DIVIDER_WE_I |=>
        CLOCK_DIVIDER_RDATA_O == ($past(CLOCK_DIVIDER_WDATA_I) & 8'hDF)) else $error("divider write lost");
    AST_FBD_KEEP: assert property (up && !PLL_FEEDBACK_DIVISOR_WE_I |=>
        $stable(PLL_FEEDBACK_DIVISOR_RDATA_O)) else $error("feedback changed unwritten");
    AST_MULT: assert property (up && $past(PLL_ENABLE_I) && PLL_ENABLE_I |=>
        SYS_MULT_O == $past(PLL_FEEDBACK_DIVISOR_RDATA_O) + 10'h002) else $error("multiplier wrong");
    AST_DIV: assert property (up && $past(PLL_ENABLE_I) && PLL_ENABLE_I |=>
        SYS_DIV_O == n1n2($past(CLOCK_DIVIDER_RDATA_O))) else $error("divisor wrong");
    AST_BYPASS: assert property (up && !$past(PLL_ENABLE_I) && !PLL_ENABLE_I |=>
        SYS_MULT_O == 10'h001 && SYS_DIV_O == 9'h001) else $error("bypass ratio wrong");
    AST_INSTR: assert property (up |-> INSTR_DIV_O == {SYS_DIV_O, 1'b0})
        else $error("instruction divisor wrong");
    AST_AUX: assert property (up |-> AUX_MULT_O == ($past(AUX_PLL_ENABLE_I) ? 5'h10 : 5'h01)
        && AUX_FINE_RES_O == $past(AUX_PLL_ENABLE_I)) else $error("aux path wrong");
    AST_REF_OFF: assert property (up && !$past(REF_ENABLE_I) && !REF_ENABLE_I |=> !REF_CLK_O)
        else $error("reference not idle");
    COV_FBD: cover property (PLL_FEEDBACK_DIVISOR_WE_I);
    COV_AUX: cover property (AUX_FINE_RES_O);
    COV_REF: cover property (REF_CLK_O);
endmodule
bind pcg_top pcg_chk u_chk (.*);

// ==== test_pll_clock_generation.sv ====
// self-checking bench for the clock generation control block
// one crystal model on the oscillator pin, all else driven here
`timescale 1ns/1ps
module test_pll_clock_generation;
    import pcg_pkg::*;
    logic CORE_CLK_I = 1'b0, RST_I = 1'b1, POR_I = 1'b1, SYS_CLK_LEVEL_I = 1'b0, PRIMARY_OSC_I;
    logic CLOCK_DIVIDER_WE_I = 1'b0, PLL_FEEDBACK_DIVISOR_WE_I = 1'b0, PLL_SRC_RC_I = 1'b0;
    logic PLL_ENABLE_I = 1'b0, AUX_SRC_RC_I = 1'b0, AUX_PLL_ENABLE_I = 1'b0;
    logic REF_ENABLE_I = 1'b0, REF_SRC_XTAL_I = 1'b0;
    logic [7:0] CLOCK_DIVIDER_WDATA_I = 8'h00, REF_RATIO_I = 8'h01, CLOCK_DIVIDER_RDATA_O;
    logic [8:0] PLL_FEEDBACK_DIVISOR_WDATA_I = 9'h000, PLL_FEEDBACK_DIVISOR_RDATA_O, SYS_DIV_O;
    logic SYS_SRC_RC_O, SYS_PLL_ACTIVE_O, PLL_LOCK_O, AUX_SRC_RC_O, AUX_FINE_RES_O, REF_CLK_O;
    logic [9:0] SYS_MULT_O, INSTR_DIV_O;
    logic [4:0] AUX_MULT_O;
    int miscompares = 0;
    int total_checks = 0;
    pcg_top #(.LOCK_CYCLES(2), .REF_RATIO_W(8)) dut (.*);
    // half period of four core cycles, edges on core falling edges, clear of rising edges
    pcg_osc_model #(.HALF_NS(160)) xo (.en_i(1'b1), .osc_o(PRIMARY_OSC_I));
    always #20 CORE_CLK_I = ~CORE_CLK_I;
    always @(posedge CORE_CLK_I) SYS_CLK_LEVEL_I <= ~SYS_CLK_LEVEL_I;
    // ****
    // shared tasks
    // ****
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK_I);
        #1;
    endtask
    task automatic wr(input logic [7:0] cd, input logic [8:0] fb);
        @(posedge CORE_CLK_I);
        CLOCK_DIVIDER_WE_I <= 1'b1;
        CLOCK_DIVIDER_WDATA_I <= cd;
        PLL_FEEDBACK_DIVISOR_WE_I <= 1'b1;
        PLL_FEEDBACK_DIVISOR_WDATA_I <= fb;
        @(posedge CORE_CLK_I);
        CLOCK_DIVIDER_WE_I <= 1'b0;
        PLL_FEEDBACK_DIVISOR_WE_I <= 1'b0;
        tick(3);
    endtask
    task automatic close_out();
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_example();
        chk("fbd reset", PLL_FEEDBACK_DIVISOR_RDATA_O, FBD_RST);
        chk("bypass div", INSTR_DIV_O, 16'h2);
        @(posedge CORE_CLK_I);
        PLL_ENABLE_I <= 1'b1;
        wr(8'h00, 9'h01E); // 10 MHz in: 5 MHz vco in, 160 MHz vco, 80 MHz out
        chk("mult", SYS_MULT_O, 16'h20);
        chk("div", SYS_DIV_O, 16'h4);
        chk("instr div", INSTR_DIV_O, 16'h8);
        chk("pll active", SYS_PLL_ACTIVE_O, 16'h1);
        chk("sys src", SYS_SRC_RC_O, 16'h0);
        chk("lock", PLL_LOCK_O, 16'h1);
    endtask
    task automatic t_post();
        for (int c = 0; c < 4; c++) begin
            wr({2'(c), 6'h3F}, 9'h000);
            chk("clock_divider rd", CLOCK_DIVIDER_RDATA_O, {2'(c), 6'h1F});
            chk("div", SYS_DIV_O, 16'(33 * (c == 0 ? 2 : (c == 1 ? 4 : 8))));
        end
        chk("mult", SYS_MULT_O, 16'h2);
    endtask
    task automatic t_src();
        @(posedge CORE_CLK_I);
        PLL_SRC_RC_I <= 1'b1; // primary pll kept far below 30 MIPS here
        AUX_SRC_RC_I <= 1'b1;
        AUX_PLL_ENABLE_I <= 1'b1; // aux output taken as 120 MHz
        tick(3);
        chk("sys src", SYS_SRC_RC_O, 16'h1);
        chk("aux src", AUX_SRC_RC_O, 16'h1);
        chk("aux mult", AUX_MULT_O, 16'h10);
        chk("fine res", AUX_FINE_RES_O, 16'h1);
        @(posedge CORE_CLK_I);
        PLL_ENABLE_I <= 1'b0;
        AUX_PLL_ENABLE_I <= 1'b0;
        tick(3);
        chk("pll active", SYS_PLL_ACTIVE_O, 16'h0);
        chk("bypass mult", SYS_MULT_O, 16'h1);
        chk("bypass div", SYS_DIV_O, 16'h1);
        chk("fine res", AUX_FINE_RES_O, 16'h0);
        chk("aux bypass", AUX_MULT_O, 16'h1);
        chk("lock off", PLL_LOCK_O, 16'h0);
    endtask
    task automatic t_keep();
        wr(8'h41, 9'h155);
        @(posedge CORE_CLK_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge CORE_CLK_I);
        RST_I <= 1'b0;
        tick(2);
        chk("fbd kept", PLL_FEEDBACK_DIVISOR_RDATA_O, 16'h155);
        chk("divider reset", CLOCK_DIVIDER_RDATA_O, CDIV_RST);
        @(posedge CORE_CLK_I);
        POR_I <= 1'b1;
        repeat (2) @(posedge CORE_CLK_I);
        POR_I <= 1'b0;
        tick(2);
        chk("fbd por", PLL_FEEDBACK_DIVISOR_RDATA_O, FBD_RST);
    endtask
    task automatic t_ref(input logic xtal, input logic [7:0] r, input int lo, input int hi);
        int n;
        logic prev;
        n = 0;
        @(posedge CORE_CLK_I);
        REF_ENABLE_I <= 1'b1;
        REF_SRC_XTAL_I <= xtal;
        REF_RATIO_I <= r;
        tick(10);
        repeat (48) begin
            prev = REF_CLK_O;
            tick(1);
            if (REF_CLK_O !== prev) n++;
        end
        chk("ref toggles", 16'(n >= lo && n <= hi), 16'h1);
        @(posedge CORE_CLK_I);
        REF_ENABLE_I <= 1'b0;
        tick(4);
        chk("ref idle", REF_CLK_O, 16'h0);
    endtask
    initial begin
        repeat (4) @(posedge CORE_CLK_I);
        RST_I <= 1'b0;
        POR_I <= 1'b0;
        tick(2);
        t_example();
        t_post();
        t_src();
        t_keep();
        t_ref(1'b0, 8'h01, 48, 48);
        t_ref(1'b0, 8'h02, 24, 24);
        t_ref(1'b0, 8'h04, 12, 12);
        t_ref(1'b1, 8'h01, 12, 12);
        close_out();
    end
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
endmodule
